// file: rtl/bus_space_defines.svh
// offsets, field positions, reset values and address bounds of the bus space unit
`ifndef BUS_SPACE_DEFINES_SVH
`define BUS_SPACE_DEFINES_SVH

// register byte offsets on the avalon slave
`define FAULT_ADDRESS_OFS      8'h00
`define BUS_STATUS_REG_OFS     8'h04
`define EXTRA_BUS_CONFIG_OFS   8'h08

// bus_status_reg fields
`define SLEEP_POLICY_MSB       18
`define SLEEP_POLICY_LSB       17
`define CORE_SLEEP_BIT         16
`define FAULT_INFO_MSB         14
`define FAULT_INFO_LSB         12
`define PARITY_LANE_MSB        11
`define PARITY_LANE_LSB        8
`define FAULT_CAUSE_MSB        6
`define FAULT_CAUSE_LSB        4
`define BUS_YIELD_BIT          1

// extra_bus_config fields
`define IROM_TWO_CYCLE_BIT     10
`define IRAM_TWO_CYCLE_BIT     9
`define ODD_POLARITY_BIT       7
`define ALL_IROM_BIT           3
`define IROM_VALID_BIT         2
`define IRAM_VALID_BIT         1

// reset values
`define SLEEP_POLICY_RST       2'h0
`define CORE_SLEEP_RST         1'h0
`define BUS_YIELD_RST          1'h0
`define ODD_POLARITY_RST       1'h0
`define FAULT_ADDRESS_RST      32'h0000_0000

// standby policy codes
`define POLICY_IMMEDIATE       2'h0
`define POLICY_AFTER_SUSPEND   2'h3

// address space bounds
`define ROM_BASE               32'h0000_0000
`define ROM_END                32'h0FFF_FFFF
`define SRAM_BASE              32'h1000_0000
`define SRAM_END               32'h1FFF_FFFF
`define DRAM_BASE              32'h2000_0000
`define DRAM_END               32'h2FFF_FFFF
`define EXT_BASE               32'h4000_0000
`define EXT_END                32'h7FFF_FFFF
`define IROM_BASE              32'hC000_0000
`define IROM_END               32'hCFFF_FFFF
`define IRAM_BASE              32'hD000_0000
`define IRAM_END               32'hDFFF_FFFF
`define REG_BASE               32'hE000_0000
`define SYSREG_BASE            32'hF800_0000
`define REG_END                32'hFFFF_FFFF

`endif

// file: rtl/bus_space_pkg.sv
// types shared by the bus space decode and status unit
package bus_space_pkg;

  typedef enum logic [2:0] {
    CAUSE_NONE    = 3'b000,
    CAUSE_PRIV    = 3'b001,
    CAUSE_PARITY  = 3'b010,
    CAUSE_INVALID = 3'b100
  } fault_cause_t;

  typedef enum logic [2:0] {
    SPACE_ROM     = 3'b000,
    SPACE_SRAM    = 3'b001,
    SPACE_DRAM    = 3'b010,
    SPACE_EXT     = 3'b011,
    SPACE_REG     = 3'b100,
    SPACE_INVALID = 3'b101
  } space_t;

  typedef struct packed {
    logic        req;         // access in progress
    logic [31:0] addr;        // access address
    logic        fetch;       // instruction fetch, else data
    logic        write;       // data write
    logic        supervisor;  // core in supervisor mode
    logic [2:0]  status;      // core access status lines
  } core_access_t;

  typedef struct packed {
    logic [31:0]  addr;
    logic [2:0]   info;
    logic [3:0]   lanes;
    fault_cause_t cause;
  } fault_rec_t;

endpackage

// file: rtl/bus_space_decode_status.sv
// address space decode, access exceptions, bus fault record and sleep/hold control
`timescale 1ns/1ps
`default_nettype none
`include "bus_space_defines.svh"

module bus_space_decode_status (
  input  wire logic                         CLOCK,             // 20 MHz system clock
  input  wire logic                         RST_N,             // synchronous reset, active low
  // avalon-mm register slave
  input  wire logic [7:0]                   AVS_ADDRESS,       // byte address
  input  wire logic                         AVS_READ,          // read request
  input  wire logic                         AVS_WRITE,         // write request
  input  wire logic [31:0]                  AVS_WRITEDATA,     // write data
  input  wire logic [3:0]                   AVS_BYTEENABLE,    // byte lanes
  output logic [31:0]                       AVS_READDATA,      // read data
  output logic                              AVS_WAITREQUEST,   // stall
  // core access side
  input  wire bus_space_pkg::core_access_t  CORE_ACC,          // current core access
  input  wire logic                         PARITY_ERR,        // parity error on current access
  input  wire logic [3:0]                   PARITY_LANES,      // lanes in error
  input  wire logic                         CORE_SUSPENDED,    // core suspend process done
  input  wire logic                         CORE_WAKE,         // wake event for the core
  input  wire logic                         BUS_YIELD_REQ,     // core bus rights request
  input  wire logic                         STANDBY_N,         // standby pin, active low
  // memory and device side
  output logic                              ROM_SEL_N,         // rom select, active low
  output logic                              SRAM_SEL_N,        // sram select, active low
  output logic                              DRAM_REQ,          // dram controller request
  output logic                              EXT_DEV_STROBE_N,  // general device strobe, active low
  output logic                              REG_SPACE_SEL,     // register space select
  output logic                              SYS_REG_SEL,       // standard io / system registers
  output logic                              INSTR_ACCESS_EXC,  // instruction access exception
  output logic                              DATA_ACCESS_EXC,   // data access exception
  output logic                              BUS_YIELD_ACK,     // bus rights handed over
  output logic                              CLOCK_STOP,        // stop system clock
  output logic                              CORE_CLOCK_STOP    // stop core clock
);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  bus_space_pkg::space_t space;
  logic                  sys_sub;
  logic                  acc_ok;
  logic                  priv_fault;
  logic [31:0]           a;

  assign a = CORE_ACC.addr;

  always_comb begin
    space   = bus_space_pkg::SPACE_INVALID;
    sys_sub = 1'b0;
    if (a <= `ROM_END) begin
      space = bus_space_pkg::SPACE_ROM;
    end else if (a >= `SRAM_BASE && a <= `SRAM_END) begin
      space = bus_space_pkg::SPACE_SRAM;
    end else if (a >= `DRAM_BASE && a <= `DRAM_END) begin
      space = bus_space_pkg::SPACE_DRAM;
    end else if (a >= `EXT_BASE && a <= `EXT_END) begin
      space = bus_space_pkg::SPACE_EXT;
    end else if (a >= `IROM_BASE && a <= `IROM_END) begin
      space = bus_space_pkg::SPACE_INVALID;
    end else if (a >= `IRAM_BASE && a <= `IRAM_END) begin
      space = bus_space_pkg::SPACE_INVALID;
    end else if (a >= `REG_BASE) begin
      space   = bus_space_pkg::SPACE_REG;
      sys_sub = (a >= `SYSREG_BASE);
    end
  end

  // register space is open to supervisor accesses only
  assign priv_fault = CORE_ACC.req && space == bus_space_pkg::SPACE_REG && !CORE_ACC.supervisor;
  assign acc_ok     = CORE_ACC.req && !priv_fault;

  assign ROM_SEL_N        = !(acc_ok && space == bus_space_pkg::SPACE_ROM);
  assign SRAM_SEL_N       = !(acc_ok && space == bus_space_pkg::SPACE_SRAM);
  assign DRAM_REQ         = acc_ok && space == bus_space_pkg::SPACE_DRAM;
  assign EXT_DEV_STROBE_N = !(acc_ok && space == bus_space_pkg::SPACE_EXT);
  assign REG_SPACE_SEL    = acc_ok && space == bus_space_pkg::SPACE_REG;
  assign SYS_REG_SEL      = REG_SPACE_SEL && sys_sub;

  logic invalid_acc;
  assign invalid_acc      = CORE_ACC.req && space == bus_space_pkg::SPACE_INVALID;
  assign INSTR_ACCESS_EXC = invalid_acc && CORE_ACC.fetch;
  assign DATA_ACCESS_EXC  = invalid_acc && !CORE_ACC.fetch;

  ////////////////////////////////////////////////////////////////////////////////
  // bus fault record

  bus_space_pkg::fault_rec_t fault_r;
  bus_space_pkg::fault_rec_t fault_nxt;
  logic                      fault_evt;

  always_comb begin
    fault_evt = 1'b1;
    fault_nxt = fault_r;
    fault_nxt.addr = a;
    fault_nxt.info = CORE_ACC.status;
    fault_nxt.lanes = 4'h0;
    if (invalid_acc) begin
      fault_nxt.cause = bus_space_pkg::CAUSE_INVALID;
    end else if (priv_fault) begin
      fault_nxt.cause = bus_space_pkg::CAUSE_PRIV;
    end else if (CORE_ACC.req && PARITY_ERR) begin
      fault_nxt.cause = bus_space_pkg::CAUSE_PARITY;
      fault_nxt.lanes = PARITY_LANES;
    end else begin
      fault_evt = 1'b0;
      fault_nxt = fault_r;
    end
  end

  // whole record written in one edge so a read never mixes two faults
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      fault_r.addr  <= `FAULT_ADDRESS_RST;
      fault_r.info  <= 3'h0;
      fault_r.lanes <= 4'h0;
      fault_r.cause <= bus_space_pkg::CAUSE_NONE;
    end else if (fault_evt) begin
      fault_r <= fault_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // standby pin synchroniser

  logic standby_n_s1_r;
  logic standby_n_s2_r;
  logic standby_n_s3_r;
  logic standby_n_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      standby_n_s1_r   <= 1'b1;
      standby_n_s2_r   <= 1'b1;
      standby_n_s3_r   <= 1'b1;
      standby_n_r <= 1'b1;
    end else begin
      standby_n_s1_r <= STANDBY_N;
      standby_n_s2_r <= standby_n_s1_r;
      standby_n_s3_r <= standby_n_s2_r;
      if (standby_n_s2_r == standby_n_s3_r) begin
        standby_n_r <= standby_n_s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [1:0] policy_r;
  logic       core_sleep_r;
  logic       bus_yield_r;
  logic       odd_polarity_r;
  logic       ack_r;
  logic       wr_stat;
  logic       wr_extra;

  assign wr_stat  = AVS_WRITE && ack_r && AVS_ADDRESS == `BUS_STATUS_REG_OFS;
  assign wr_extra = AVS_WRITE && ack_r && AVS_ADDRESS == `EXTRA_BUS_CONFIG_OFS;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      policy_r <= `SLEEP_POLICY_RST;
    end else if (wr_stat && AVS_BYTEENABLE[2]) begin
      policy_r <= AVS_WRITEDATA[`SLEEP_POLICY_MSB:`SLEEP_POLICY_LSB];
    end
  end

  // wake wins over a write of one in the same cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      core_sleep_r <= `CORE_SLEEP_RST;
    end else if (CORE_WAKE) begin
      core_sleep_r <= 1'b0;
    end else if (wr_stat && AVS_BYTEENABLE[2] && AVS_WRITEDATA[`CORE_SLEEP_BIT]) begin
      core_sleep_r <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      bus_yield_r <= `BUS_YIELD_RST;
    end else if (wr_stat && AVS_BYTEENABLE[0]) begin
      bus_yield_r <= AVS_WRITEDATA[`BUS_YIELD_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      odd_polarity_r <= `ODD_POLARITY_RST;
    end else if (wr_extra && AVS_BYTEENABLE[0]) begin
      odd_polarity_r <= AVS_WRITEDATA[`ODD_POLARITY_BIT];
    end
  end

  assign BUS_YIELD_ACK   = BUS_YIELD_REQ && bus_yield_r;
  assign CORE_CLOCK_STOP = core_sleep_r;

  // clock stop for standby, by policy
  always_comb begin
    CLOCK_STOP = 1'b0;
    if (!standby_n_r) begin
      case (policy_r)
        `POLICY_IMMEDIATE:     CLOCK_STOP = 1'b1;
        `POLICY_AFTER_SUSPEND: CLOCK_STOP = CORE_SUSPENDED;
        default:               CLOCK_STOP = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then accept

  logic [31:0] stat_word;
  logic [31:0] extra_word;
  logic [31:0] rd_mux;
  logic [31:0] readdata_r;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`SLEEP_POLICY_MSB:`SLEEP_POLICY_LSB] = policy_r;
    stat_word[`CORE_SLEEP_BIT] = core_sleep_r | CORE_SUSPENDED;
    stat_word[`FAULT_INFO_MSB:`FAULT_INFO_LSB] = fault_r.info;
    stat_word[`PARITY_LANE_MSB:`PARITY_LANE_LSB] = fault_r.lanes;
    stat_word[`FAULT_CAUSE_MSB:`FAULT_CAUSE_LSB] = fault_r.cause;
    stat_word[`BUS_YIELD_BIT] = bus_yield_r;
    extra_word = 32'h0000_0000;
    extra_word[`IROM_TWO_CYCLE_BIT] = 1'b0;
    extra_word[`IRAM_TWO_CYCLE_BIT] = 1'b0;
    extra_word[`ODD_POLARITY_BIT] = odd_polarity_r;
    extra_word[`ALL_IROM_BIT] = 1'b0;
    extra_word[`IROM_VALID_BIT] = 1'b0;
    extra_word[`IRAM_VALID_BIT] = 1'b0;
    case (AVS_ADDRESS)
      `FAULT_ADDRESS_OFS:    rd_mux = fault_r.addr;
      `BUS_STATUS_REG_OFS:   rd_mux = stat_word;
      `EXTRA_BUS_CONFIG_OFS: rd_mux = extra_word;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      readdata_r <= 32'h0000_0000;
    end else if (AVS_READ && !ack_r) begin
      readdata_r <= rd_mux;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
  assign AVS_READDATA    = readdata_r;

endmodule

`default_nettype wire

// file: bench/bus_space_decode_status_asserts.sv
// port assertions of the bus space decode and status unit
`timescale 1ns/1ps
`default_nettype none

module bus_space_decode_status_asserts (
  input wire logic                        CLOCK,            // clock
  input wire logic                        RST_N,            // reset
  input wire logic [7:0]                  AVS_ADDRESS,      // address
  input wire logic                        AVS_READ,         // read
  input wire logic                        AVS_WRITE,        // write
  input wire logic [31:0]                 AVS_WRITEDATA,    // write data
  input wire logic [3:0]                  AVS_BYTEENABLE,   // lanes
  input wire logic [31:0]                 AVS_READDATA,     // read data
  input wire logic                        AVS_WAITREQUEST,  // stall
  input wire bus_space_pkg::core_access_t CORE_ACC,         // core access
  input wire logic                        BUS_YIELD_REQ,    // bus request
  input wire logic                        ROM_SEL_N,        // rom select
  input wire logic                        SRAM_SEL_N,       // sram select
  input wire logic                        DRAM_REQ,         // dram request
  input wire logic                        EXT_DEV_STROBE_N, // device strobe
  input wire logic                        SYS_REG_SEL,      // system registers
  input wire logic                        INSTR_ACCESS_EXC, // fetch exception
  input wire logic                        DATA_ACCESS_EXC,  // data exception
  input wire logic                        BUS_YIELD_ACK,    // bus granted
  input wire logic                        CORE_CLOCK_STOP   // core clock off
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire logic [3:0] nib = CORE_ACC.addr[31:28];
  wire logic       rq = CORE_ACC.req;
  wire logic       bad = rq && (nib inside {4'h3, [4'h8:4'hD]});
  wire logic       wr_slp = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h04 && AVS_WRITEDATA[16] && AVS_BYTEENABLE[2];
  ////////////////////////////////////////////////////////////////////
  property p_rom; rq && nib == 4'h0 |-> !ROM_SEL_N && SRAM_SEL_N; endproperty
  a_rom: assert property (p_rom) else $error("rom select wrong");
  property p_sram; rq && nib == 4'h1 |-> !SRAM_SEL_N && ROM_SEL_N; endproperty
  a_sram: assert property (p_sram) else $error("sram select wrong");
  property p_dram; rq && nib == 4'h2 |-> DRAM_REQ && EXT_DEV_STROBE_N; endproperty
  a_dram: assert property (p_dram) else $error("dram request wrong");
  property p_ext; rq && nib[3:2] == 2'b01 |-> !EXT_DEV_STROBE_N && !DRAM_REQ; endproperty
  a_ext: assert property (p_ext) else $error("device strobe wrong");
  property p_irom;
    rq && nib == 4'hC |-> INSTR_ACCESS_EXC == CORE_ACC.fetch && DATA_ACCESS_EXC == !CORE_ACC.fetch;
  endproperty
  a_irom: assert property (p_irom) else $error("internal rom access not refused");
  property p_iram;
    rq && nib == 4'hD |-> INSTR_ACCESS_EXC == CORE_ACC.fetch && DATA_ACCESS_EXC == !CORE_ACC.fetch;
  endproperty
  a_iram: assert property (p_iram) else $error("internal ram access not refused");
  property p_exc; INSTR_ACCESS_EXC || DATA_ACCESS_EXC |-> bad; endproperty
  a_exc: assert property (p_exc) else $error("exception on a valid space");
  property p_sys; rq && CORE_ACC.supervisor && CORE_ACC.addr[31:27] == 5'h1F |-> SYS_REG_SEL; endproperty
  a_sys: assert property (p_sys) else $error("system register select missing");
  property p_yield; BUS_YIELD_ACK |-> BUS_YIELD_REQ; endproperty
  a_yield: assert property (p_yield) else $error("bus granted unasked");
  property p_cfg;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h08 |-> AVS_READDATA[10:9] == 2'h0 && AVS_READDATA[3:1] == 3'h0;
  endproperty
  a_cfg: assert property (p_cfg) else $error("fixed config bits not zero");
  property p_sleep; $rose(CORE_CLOCK_STOP) |-> $past(wr_slp); endproperty
  a_sleep: assert property (p_sleep) else $error("core clock stopped unasked");
  c_iexc: cover property (INSTR_ACCESS_EXC);
  c_dexc: cover property (DATA_ACCESS_EXC);
  c_sleep: cover property ($rose(CORE_CLOCK_STOP));
endmodule

bind bus_space_decode_status bus_space_decode_status_asserts chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CORE_ACC(CORE_ACC), .BUS_YIELD_REQ(BUS_YIELD_REQ),
  .ROM_SEL_N(ROM_SEL_N), .SRAM_SEL_N(SRAM_SEL_N), .DRAM_REQ(DRAM_REQ), .EXT_DEV_STROBE_N(EXT_DEV_STROBE_N),
  .SYS_REG_SEL(SYS_REG_SEL), .INSTR_ACCESS_EXC(INSTR_ACCESS_EXC), .DATA_ACCESS_EXC(DATA_ACCESS_EXC),
  .BUS_YIELD_ACK(BUS_YIELD_ACK), .CORE_CLOCK_STOP(CORE_CLOCK_STOP));
`default_nettype wire

// file: bench/ext_space_model.sv
// external memories and devices: who answers, and sram parity faults on demand
`timescale 1ns/1ps
`default_nettype none

module ext_space_model (
  input  wire logic       rom_sel_n,    // rom select
  input  wire logic       sram_sel_n,   // sram select
  input  wire logic       dram_req,     // dram request
  input  wire logic       ext_strobe_n, // device strobe
  input  wire logic       inject,       // spoil any sram word selected while high
  input  wire logic [3:0] lanes_in,     // lanes to spoil
  output logic [3:0]      hit,          // answering device {ext,dram,sram,rom}
  output logic            parity_err,   // parity fault
  output logic [3:0]      parity_lanes  // lanes in fault
);
  assign hit = {!ext_strobe_n, dram_req, !sram_sel_n, !rom_sel_n};
  assign parity_err = inject && !sram_sel_n;
  // lanes not in fault show the inverse pattern, zero only when lanes_in is all ones
  assign parity_lanes = parity_err ? lanes_in : ~lanes_in;
endmodule
`default_nettype wire

// file: bench/bus_space_decode_status_bench.sv
// self-checking bench of the bus space decode and status unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %h got %h", n, e, g); err_count++; end end

module bus_space_decode_status_bench;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0, wr = 1'b0, inj = 1'b0, susp = 1'b0, wake = 1'b0, yreq = 1'b0, standby_n_n = 1'b1;
  logic [31:0] wdat = 32'h0, rdata, rv, seed = 32'h0000_005F;
  logic [3:0]  be = 4'hF, lns = 4'h0, plns, hit, nib;
  logic        wreq, perr, rom_n, sram_n, dreq, ext_n, regsel, syssel, iexc, dexc, yack, cstop, ccstop;
  logic        bad, rg, pv, pe, m_slp, m_yld;
  logic [1:0]  m_pol;
  int          err_count = 0, num_checks = 0;
  bus_space_pkg::core_access_t acc = '0;
  bus_space_pkg::fault_rec_t   f;

  always #25 clock = ~clock;

  bus_space_decode_status dut (.CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .CORE_ACC(acc),
    .PARITY_ERR(perr), .PARITY_LANES(plns), .CORE_SUSPENDED(susp), .CORE_WAKE(wake), .BUS_YIELD_REQ(yreq),
    .STANDBY_N(standby_n_n), .ROM_SEL_N(rom_n), .SRAM_SEL_N(sram_n), .DRAM_REQ(dreq), .EXT_DEV_STROBE_N(ext_n),
    .REG_SPACE_SEL(regsel), .SYS_REG_SEL(syssel), .INSTR_ACCESS_EXC(iexc), .DATA_ACCESS_EXC(dexc),
    .BUS_YIELD_ACK(yack), .CLOCK_STOP(cstop), .CORE_CLOCK_STOP(ccstop));
  ext_space_model far (.rom_sel_n(rom_n), .sram_sel_n(sram_n), .dram_req(dreq), .ext_strobe_n(ext_n),
    .inject(inj), .lanes_in(lns), .hit(hit), .parity_err(perr), .parity_lanes(plns));

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] bus_status_control();
    return {13'h0, m_pol, m_slp | susp, 1'b0, f.info, f.lanes, 1'b0, f.cause, 2'b00, m_yld, 1'b0};
  endfunction
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    f = '0;
    {m_pol, m_slp, m_yld} = '0;
  endtask
  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clock);
    adr <= a;
    wdat <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do begin @(posedge clock); n++; end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) begin err_count++; summarize(); end
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    `CHK("readdata", e, rv)
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    summarize();
  end
  initial begin
    do_reset();
    chk_rd(8'h00, 32'h0);
    chk_rd(8'h04, 32'h0);
    xfer(1'b1, 8'h04, 32'hFFFF_FFFF, 4'hF);
    {m_pol, m_slp, m_yld} = 4'hF;
    chk_rd(8'h04, bus_status_control());
    `CHK("core clock stop", 1'b1, ccstop)
    yreq <= 1'b1;
    @(posedge clock);
    `CHK("yield ack", 1'b1, yack)
    xfer(1'b1, 8'h04, 32'h0, 4'hB);
    m_yld = 1'b0;
    chk_rd(8'h04, bus_status_control());
    `CHK("yield ack", 1'b0, yack)
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    @(posedge clock);
    m_slp = 1'b0;
    `CHK("core clock stop", 1'b0, ccstop)
    chk_rd(8'h08, 32'h0);
    xfer(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF);
    chk_rd(8'h08, 32'h0000_0080);
    xfer(1'b1, 8'h08, 32'h0, 4'hE);
    xfer(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
    xfer(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hF);
    chk_rd(8'h0C, 32'h0);
    chk_rd(8'h00, 32'h0);
    chk_rd(8'h08, 32'h0000_0080);
    for (int p = 0; p < 4; p++) for (int s = 0; s < 2; s++) begin
      xfer(1'b1, 8'h04, 32'(p) << 17, 4'hF);
      m_pol = p[1:0];
      susp <= s[0];
      standby_n_n <= 1'b0;
      repeat (6) @(posedge clock);
      `CHK("clock stop", (p == 0) || (p == 3 && s == 1), cstop)
      chk_rd(8'h04, bus_status_control());
      standby_n_n <= 1'b1;
      repeat (6) @(posedge clock);
      `CHK("clock stop", 1'b0, cstop)
    end
    susp <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      @(posedge clock);
      acc <= '{1'b1, {i[3:0], seed[27:0]}, seed[28], seed[29], seed[30], seed[2:0]};
      inj <= seed[31];
      lns <= seed[7:4];
      nib = i[3:0];
      bad = nib inside {4'h3, [4'h8:4'hD]};
      rg = nib >= 4'hE;
      pv = rg && !seed[30];
      pe = nib == 4'h1 && seed[31];
      @(posedge clock);
      `CHK("rom sel", !(nib == 4'h0), rom_n)
      `CHK("sram sel", !(nib == 4'h1), sram_n)
      `CHK("dram req", nib == 4'h2, dreq)
      `CHK("ext strobe", !(nib[3:2] == 2'b01), ext_n)
      `CHK("device hit", {nib[3:2] == 2'b01, nib == 4'h2, nib == 4'h1, nib == 4'h0}, hit)
      `CHK("instr exc", bad && seed[28], iexc)
      `CHK("data exc", bad && !seed[28], dexc)
      `CHK("reg sel", rg && seed[30], regsel)
      `CHK("sys sel", nib == 4'hF && seed[30] && seed[27], syssel)
      if (bad || pv || pe) f = '{{i[3:0], seed[27:0]}, seed[2:0], pe ? seed[7:4] : 4'h0,
        bad ? bus_space_pkg::CAUSE_INVALID : pv ? bus_space_pkg::CAUSE_PRIV : bus_space_pkg::CAUSE_PARITY};
      acc.req <= 1'b0;
      chk_rd(8'h00, f.addr);
      chk_rd(8'h04, bus_status_control());
    end
    // directed sram parity fault, so the lane record is always exercised
    @(posedge clock);
    acc <= '{1'b1, 32'h1234_5678, 1'b0, 1'b1, 1'b0, 3'h5};
    inj <= 1'b1;
    lns <= 4'hA;
    @(posedge clock);
    `CHK("sram sel", 1'b0, sram_n)
    `CHK("parity err", 1'b1, perr)
    acc.req <= 1'b0;
    inj <= 1'b0;
    f = '{32'h1234_5678, 3'h5, 4'hA, bus_space_pkg::CAUSE_PARITY};
    chk_rd(8'h04, bus_status_control());
    chk_rd(8'h00, f.addr);
    do_reset();
    chk_rd(8'h04, 32'h0);
    chk_rd(8'h00, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
